// ### verilog/prot_defs.svh
// register offsets, field positions, reset values of the protection frame
`ifndef PROT_DEFS_SVH
`define PROT_DEFS_SVH

// byte offsets on the apb bus
`define PROT_CTRL_OFS      12'h000
`define PROT_SUPERV_OFS    12'h004
`define PROT_SINGLE_OFS    12'h008
`define PROT_GROUND_OFS    12'h00c
`define PROT_STATUS_OFS    12'h010
`define PROT_IRQ_STAT_OFS  12'h014
`define PROT_IRQ_MASK_OFS  12'h018
`define PROT_STAGE_OFS     12'h01c
`define PROT_MAP_BASE      12'h020
`define PROT_DELAY_BASE    12'h040
`define PROT_DELAY_END     12'h080

// control register fields
`define PROT_CTRL_FUNC_BIT 0
`define PROT_CTRL_XBLK_BIT 1
`define PROT_CTRL_PINH_BIT 2
`define PROT_CTRL_XINH_BIT 3

// interrupt status and mask fields
`define PROT_IRQ_ALARM_BIT 0
`define PROT_IRQ_TRIP_BIT  1
`define PROT_IRQ_GND_BIT   2
`define PROT_IRQ_CMD_BIT   3

// reset values
`define PROT_CTRL_RST      4'h1
`define PROT_DELAY_RST     16'h0010

`endif

// ### verilog/prot_pkg.sv
// types shared by the protection frame and its users
package prot_pkg;

	// global protection settings
	typedef struct packed {
		logic ext_inhibit_feature;
		logic permanent_command_inhibit;
		logic external_block_feature;
		logic function_en;
	} ctrl_t;

	// collective signals of the frame
	typedef struct packed {
		logic       general_alarm;
		logic       general_trip;
		logic       ground_alarm;
		logic [2:0] phase_alarm;
		logic [2:0] phase_trip;
	} collective_t;

	// interrupt events
	typedef struct packed {
		logic command;
		logic ground;
		logic trip;
		logic alarm;
	} irq_t;

	// external blocking inputs, asynchronous to pclk
	typedef struct packed {
		logic external_block_in_a;
		logic external_block_in_b;
		logic external_command_inhibit_in;
	} block_in_t;

endpackage

// ### verilog/protection_alarm_trip_aggregator.sv
// protection master frame: stage timers, collective alarms and trips, command gating
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "prot_defs.svh"

// Overview of operation
// - function inactive or frame blocked disables every alarm, trip and command.
// - with external block feature on, either block input blocks all protection.
// - permanent command inhibit suppresses commands, alarms and trips still run.
// - with inhibit feature on, the inhibit input suppresses all commands.
// - each stage raises its alarm as soon as its fault criterion appears.
// - general alarm is the OR of all reporting stage alarms.
// - stage trips only if fault persists once its delay timer expired.
// - general trip is the OR of all reporting stage trips.
// - a tripping stage issues its command unless commands are inhibited.
// - commands and their inhibit exist only for non supervision stages.
// - a breaker opens only on commands assigned to its trip manager.
// - per phase general alarm is the OR of that phase's stage alarms.
// - per phase general trip is the OR of that phase's stage trips.
// - only single phase capable, non supervision stages feed phase signals.
// - alarms from ground stages also raise the collective ground alarm.
// - supervision only stages feed nothing into the collective signals.
// - supervision only stages never operate any breaker.
module protection_alarm_trip_aggregator #(
	parameter int NSTAGE = 8,
	parameter int NBRK   = 2
) (
	// clock and reset
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	// apb slave
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [11:0]                     paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	// stage fault criteria per phase, same clock
	input  wire logic [NSTAGE-1:0][2:0]          fault_phase,
	// external blocking pins
	input  wire prot_pkg::block_in_t             block_in,
	// stage results
	output logic      [NSTAGE-1:0]               stage_alarm,
	output logic      [NSTAGE-1:0]               stage_trip,
	output logic      [NSTAGE-1:0]               stage_open_command,
	// collective signals and breakers
	output prot_pkg::collective_t                collective,
	output logic      [NBRK-1:0]                 breaker_open,
	output logic                                 irq
);
	import prot_pkg::*;

	typedef struct packed {
		block_in_t                    sync1;
		block_in_t                    sync2;
		ctrl_t                        ctrl;
		logic [NSTAGE-1:0]            superv;
		logic [NSTAGE-1:0]            single_phase;
		logic [NSTAGE-1:0]            ground;
		logic [NBRK-1:0][NSTAGE-1:0]  brk_map;
		logic [NSTAGE-1:0][15:0]      delay;
		logic [NSTAGE-1:0][15:0]      timer;
		logic [NSTAGE-1:0]            alarm;
		logic [NSTAGE-1:0]            trip;
		logic [NSTAGE-1:0]            cmd;
		logic [NSTAGE-1:0][2:0]       ph_alarm;
		logic [NSTAGE-1:0][2:0]       ph_trip;
		collective_t                  coll;
		logic [NBRK-1:0]              brk_open;
		irq_t                         irq_stat;
		irq_t                         irq_mask;
		logic                         irq;
		logic [31:0]                  prdata;
		logic                         pslverr;
	} state_t;

	state_t st;
	state_t next_st;

	// live conditions derived from registered state, the stage fault inputs and the apb bus
	logic              prot_active;
	logic              cmd_inhibit;
	logic [NSTAGE-1:0] fault_any;
	logic [NSTAGE-1:0] expired;
	logic [NSTAGE-1:0] reporting;
	logic [NSTAGE-1:0] phase_rep;
	logic              setup;
	logic              wr;
	irq_t              irq_event;

	// frame disabled by setting or by external block
	assign prot_active = st.ctrl.function_en &
		~(st.ctrl.external_block_feature &
		(st.sync2.external_block_in_a | st.sync2.external_block_in_b));
	assign cmd_inhibit = st.ctrl.permanent_command_inhibit |
		(st.ctrl.ext_inhibit_feature & st.sync2.external_command_inhibit_in);
	assign reporting = ~st.superv;
	assign phase_rep = st.single_phase & ~st.superv;
	assign setup     = psel & ~penable;
	assign wr        = psel & penable & pwrite;

	// per stage fault and timer expiry
	always_comb begin
		for (int s = 0; s < NSTAGE; s++) begin
			fault_any[s] = |fault_phase[s];
			expired[s]   = st.timer[s] >= st.delay[s];
		end
	end

	// next state: stages, collectives, interrupts, registers
	always_comb begin
		next_st = st;
		// blocking pins pass two flops before use
		next_st.sync1 = block_in;
		next_st.sync2 = st.sync1;

		// stage timers restart whenever fault drops or frame is disabled
		for (int s = 0; s < NSTAGE; s++) begin
			if (!prot_active || !fault_any[s]) begin
				next_st.timer[s] = 16'h0000;
			end else if (!expired[s]) begin
				next_st.timer[s] = st.timer[s] + 16'h0001;
			end
			next_st.alarm[s]    = prot_active & fault_any[s];
			next_st.ph_alarm[s] = prot_active ? fault_phase[s] : 3'h0;
			next_st.trip[s]     = prot_active & fault_any[s] & expired[s];
			next_st.ph_trip[s]  = (prot_active & expired[s]) ? fault_phase[s] : 3'h0;
		end

		// commands only from protection stages that trip, unless inhibited
		next_st.cmd = st.trip & reporting & {NSTAGE{~cmd_inhibit & prot_active}};

		// collective signals from reporting stages only
		next_st.coll.general_alarm = |(st.alarm & reporting);
		next_st.coll.general_trip  = |(st.trip & reporting);
		next_st.coll.ground_alarm  = |(st.alarm & st.ground & reporting);
		for (int p = 0; p < 3; p++) begin
			next_st.coll.phase_alarm[p] = 1'b0;
			next_st.coll.phase_trip[p]  = 1'b0;
			for (int s = 0; s < NSTAGE; s++) begin
				next_st.coll.phase_alarm[p] |= st.ph_alarm[s][p] & phase_rep[s];
				next_st.coll.phase_trip[p]  |= st.ph_trip[s][p] & phase_rep[s];
			end
		end

		// each breaker's trip manager takes only its assigned commands
		for (int b = 0; b < NBRK; b++) begin
			next_st.brk_open[b] = |(st.cmd & st.brk_map[b]);
		end

		// rising general alarm, general trip, ground alarm and first command are interrupt events
		irq_event.alarm   = next_st.coll.general_alarm & ~st.coll.general_alarm;
		irq_event.trip    = next_st.coll.general_trip & ~st.coll.general_trip;
		irq_event.ground  = next_st.coll.ground_alarm & ~st.coll.ground_alarm;
		irq_event.command = (|next_st.cmd) & ~(|st.cmd);

		// register writes, taken in the access phase
		if (wr) begin
			unique case (paddr)
				`PROT_CTRL_OFS: begin
					next_st.ctrl.function_en               = pwdata[`PROT_CTRL_FUNC_BIT];
					next_st.ctrl.external_block_feature    = pwdata[`PROT_CTRL_XBLK_BIT];
					next_st.ctrl.permanent_command_inhibit = pwdata[`PROT_CTRL_PINH_BIT];
					next_st.ctrl.ext_inhibit_feature       = pwdata[`PROT_CTRL_XINH_BIT];
				end
				`PROT_SUPERV_OFS: next_st.superv       = pwdata[NSTAGE-1:0];
				`PROT_SINGLE_OFS: next_st.single_phase = pwdata[NSTAGE-1:0];
				`PROT_GROUND_OFS: next_st.ground       = pwdata[NSTAGE-1:0];
				`PROT_IRQ_MASK_OFS: next_st.irq_mask   = irq_t'(pwdata[3:0]);
				default: begin
					for (int b = 0; b < NBRK; b++) begin
						if (paddr == `PROT_MAP_BASE + 12'(4 * b)) begin
							next_st.brk_map[b] = pwdata[NSTAGE-1:0];
						end
					end
					for (int s = 0; s < NSTAGE; s++) begin
						if (paddr == `PROT_DELAY_BASE + 12'(4 * s)) begin
							next_st.delay[s] = pwdata[15:0];
						end
					end
				end
			endcase
		end

		// sticky status, write one to clear, a new event wins over the clear
		next_st.irq_stat = st.irq_stat;
		if (wr && paddr == `PROT_IRQ_STAT_OFS) begin
			next_st.irq_stat = irq_t'(st.irq_stat & ~pwdata[3:0]);
		end
		next_st.irq_stat = irq_t'(next_st.irq_stat | irq_event);
		next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);

		// read data prepared in the setup phase so it comes from flops
		next_st.prdata  = 32'h0000_0000;
		next_st.pslverr = 1'b0;
		if (setup) begin
			unique case (paddr)
				`PROT_CTRL_OFS:     next_st.prdata[3:0] = st.ctrl;
				`PROT_SUPERV_OFS:   next_st.prdata[NSTAGE-1:0] = st.superv;
				`PROT_SINGLE_OFS:   next_st.prdata[NSTAGE-1:0] = st.single_phase;
				`PROT_GROUND_OFS:   next_st.prdata[NSTAGE-1:0] = st.ground;
				`PROT_STATUS_OFS:   next_st.prdata[10:0] = {cmd_inhibit, prot_active,
					st.coll.phase_trip, st.coll.phase_alarm, st.coll.ground_alarm,
					st.coll.general_trip, st.coll.general_alarm};
				`PROT_IRQ_STAT_OFS: next_st.prdata[3:0] = st.irq_stat;
				`PROT_IRQ_MASK_OFS: next_st.prdata[3:0] = st.irq_mask;
				`PROT_STAGE_OFS: begin
					next_st.prdata[NSTAGE-1:0]     = st.alarm;
					next_st.prdata[NSTAGE+15:16]   = st.trip;
				end
				default: begin
					next_st.pslverr = 1'b1;
					for (int b = 0; b < NBRK; b++) begin
						if (paddr == `PROT_MAP_BASE + 12'(4 * b)) begin
							next_st.prdata[NSTAGE-1:0] = st.brk_map[b];
							next_st.pslverr = 1'b0;
						end
					end
					for (int s = 0; s < NSTAGE; s++) begin
						if (paddr == `PROT_DELAY_BASE + 12'(4 * s)) begin
							next_st.prdata[15:0] = st.delay[s];
							next_st.pslverr = 1'b0;
						end
					end
				end
			endcase
		end else if (psel) begin
			// hold the answer through the access phase
			next_st.prdata  = st.prdata;
			next_st.pslverr = st.pslverr;
		end
	end

	// single state register, constants only under reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st              <= '0;
			st.ctrl         <= ctrl_t'(`PROT_CTRL_RST);
			st.delay        <= {NSTAGE{`PROT_DELAY_RST}};
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flops, pslverr gated by psel and penable; slave is always ready
	assign pready             = 1'b1;
	assign prdata             = st.prdata;
	assign pslverr            = st.pslverr & psel & penable;
	assign stage_alarm        = st.alarm;
	assign stage_trip         = st.trip;
	assign stage_open_command = st.cmd;
	assign collective         = st.coll;
	assign breaker_open       = st.brk_open;
	assign irq                = st.irq;

	// helper history for the checks
	logic [NSTAGE-1:0] alarm_cause;
	logic [NSTAGE-1:0] trip_cause;
	logic [NSTAGE-1:0] cmd_cause;
	logic              ground_cause;
	assign alarm_cause  = fault_any & {NSTAGE{prot_active}};
	assign trip_cause   = fault_any & expired & {NSTAGE{prot_active}};
	assign cmd_cause    = st.trip & reporting & {NSTAGE{~cmd_inhibit & prot_active}};
	assign ground_cause = |(st.alarm & st.ground & reporting);

	a_disable_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!prot_active |=> (st.alarm == '0 && st.trip == '0 ##1 st.cmd == '0))
		else $error("protection disabled yet a stage raised alarm, trip or command");

	a_ext_block: assert property (@(posedge pclk) disable iff (!presetn)
		(st.ctrl.external_block_feature && st.ctrl.function_en &&
		(st.sync2.external_block_in_a || st.sync2.external_block_in_b)) |=> st.alarm == '0)
		else $error("external block asserted but alarms not blocked");

	a_cmd_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_inhibit |=> st.cmd == '0)
		else $error("command issued while commands are inhibited");

	a_alarm_follows: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> st.alarm == $past(alarm_cause))
		else $error("stage alarm does not follow its fault criterion");

	a_trip_timer: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> st.trip == $past(trip_cause))
		else $error("stage trip without expired timer and live fault");

	a_timer_restart: assert property (@(posedge pclk) disable iff (!presetn)
		(!fault_any[0]) |=> st.timer[0] == 16'h0000)
		else $error("stage timer not restarted after fault dropped");

	a_general_sum: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(st.coll.general_trip) |-> $past(|st.trip) && $past(st.coll.general_alarm || |st.alarm))
		else $error("general trip rose without a reporting stage trip");

	a_cmd_gate: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> st.cmd == $past(cmd_cause))
		else $error("stage command differs from gated stage trip");

	a_breaker_map: assert property (@(posedge pclk) disable iff (!presetn)
		st.brk_open[0] |-> $past(|(st.cmd & st.brk_map[0])))
		else $error("breaker opened without an assigned command");

	a_ground_alarm: assert property (@(posedge pclk) disable iff (!presetn)
		ground_cause |=> st.coll.ground_alarm)
		else $error("ground stage alarm did not raise ground collective");

	a_phase_alarm: assert property (@(posedge pclk) disable iff (!presetn)
		st.coll.phase_alarm[0] |-> $past(|(phase_rep & st.alarm)))
		else $error("phase alarm without a reporting single phase stage");

	// phase a share of every stage, one bit per stage so the phase checks stay short
	logic [NSTAGE-1:0] phase_a_alarm;
	always_comb begin
		for (int s = 0; s < NSTAGE; s++) begin
			phase_a_alarm[s] = st.ph_alarm[s][0];
		end
	end

	a_phase_alarm_set: assert property (@(posedge pclk) disable iff (!presetn)
		|(phase_a_alarm & phase_rep) |=> st.coll.phase_alarm[0])
		else $error("phase a stage alarm did not raise the phase a collective");

	a_phase_trip: assert property (@(posedge pclk) disable iff (!presetn)
		st.coll.phase_trip[0] |-> $past(|(phase_rep & st.trip)))
		else $error("phase trip without a reporting single phase stage trip");

	a_general_alarm: assert property (@(posedge pclk) disable iff (!presetn)
		|(st.alarm & ~st.superv) |=> st.coll.general_alarm)
		else $error("reporting stage alarm did not raise the general alarm");

	a_alarm_source: assert property (@(posedge pclk) disable iff (!presetn)
		st.coll.general_alarm |-> $past(|(st.alarm & ~st.superv)))
		else $error("general alarm without a reporting stage alarm");

	a_general_trip: assert property (@(posedge pclk) disable iff (!presetn)
		|(st.trip & ~st.superv) |=> st.coll.general_trip)
		else $error("reporting stage trip did not raise the general trip");

	a_trip_source: assert property (@(posedge pclk) disable iff (!presetn)
		st.coll.general_trip |-> $past(|(st.trip & ~st.superv)))
		else $error("general trip without a reporting stage trip");

	a_superv_no_cmd: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (st.cmd & $past(st.superv)) == '0)
		else $error("supervision only stage issued a command");

	a_cmd_needs_trip: assert property (@(posedge pclk) disable iff (!presetn)
		st.cmd != '0 |-> $past(st.trip != '0) && $past(!cmd_inhibit))
		else $error("command without a stage trip or while inhibited");

	a_breaker_cause: assert property (@(posedge pclk) disable iff (!presetn)
		|(st.cmd & st.brk_map[0]) |=> st.brk_open[0])
		else $error("assigned command did not open its breaker");

	a_ground_source: assert property (@(posedge pclk) disable iff (!presetn)
		st.coll.ground_alarm |-> $past(ground_cause))
		else $error("ground collective without a reporting ground stage alarm");

	a_trip_has_alarm: assert property (@(posedge pclk) disable iff (!presetn)
		st.trip != '0 |-> (st.trip & ~st.alarm) == '0)
		else $error("stage trip without its own alarm");

	a_inhibit_keeps: assert property (@(posedge pclk) disable iff (!presetn)
		(cmd_inhibit && prot_active && fault_any != '0) |=> st.alarm != '0)
		else $error("command inhibit also suppressed the alarms");

	a_timer_count: assert property (@(posedge pclk) disable iff (!presetn)
		(prot_active && fault_any[0] && !expired[0]) |=>
		st.timer[0] == $past(st.timer[0]) + 16'h0001)
		else $error("stage timer did not advance while the fault lasted");

	a_timer_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(prot_active && fault_any[0] && expired[0]) |=> st.timer[0] == $past(st.timer[0]))
		else $error("stage timer moved after it expired");

endmodule

// ### tb/stage_model.sv
// stage side model: fault criteria and blocking pins seen by the frame
`timescale 1ns/1ps
module stage_model #(
	parameter int NS = 4
) (
	// fault criteria per stage and phase
	output logic [NS-1:0][2:0]   fault_phase,
	// blocking pins
	output prot_pkg::block_in_t  block_in
);
	import prot_pkg::*;

	// quiet plant at time zero
	initial begin
		fault_phase = '0;
		block_in = '0;
	end

	// a criterion is a level held for as long as the fault lasts
	task automatic apply(input int s, input logic [2:0] p);
		fault_phase[s] <= p;
	endtask

	// every fault gone at once
	task automatic clear_all();
		fault_phase <= '0;
	endtask

	// pins are plain levels, not pulses
	task automatic set_block(input logic [2:0] b);
		block_in <= b;
	endtask
endmodule

// ### tb/testbench.sv
// self-checking bench of the protection frame
`timescale 1ns/1ps
`include "prot_defs.svh"
module testbench;
	import prot_pkg::*;
	localparam int NS = 4;
	logic                pclk;
	logic                presetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [11:0]         paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic [31:0]         rd;
	logic                pready;
	logic                pslverr;
	logic                err;
	logic                irq;
	logic [NS-1:0][2:0]  fault_phase;
	block_in_t           block_in;
	logic [NS-1:0]       stage_alarm;
	logic [NS-1:0]       stage_trip;
	logic [NS-1:0]       stage_open_command;
	collective_t         collective;
	logic [1:0]          breaker_open;
	logic [31:0]         lfsr;
	logic [2:0]          p;
	int                  s;
	int                  mismatches;
	int                  check_count;
	logic [3:0]          ctl [6] = '{4'h0, 4'h3, 4'h3, 4'h5, 4'h9, 4'h1};
	logic [2:0]          pin [6] = '{3'h0, 3'h4, 3'h2, 3'h0, 3'h1, 3'h7};
	logic [1:0]          pass [6] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h3};

	protection_alarm_trip_aggregator #(.NSTAGE(NS), .NBRK(2)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fault_phase(fault_phase),
		.block_in(block_in), .stage_alarm(stage_alarm), .stage_trip(stage_trip),
		.stage_open_command(stage_open_command), .collective(collective),
		.breaker_open(breaker_open), .irq(irq)
	);
	stage_model #(.NS(NS)) model (.fault_phase(fault_phase), .block_in(block_in));

	// free-running clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// hang guard, far above the planned run
	initial begin
		#4000000;
		mismatches++;
		print_verdict();
	end

	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// stage 0 single phase, stage 1 supervision, others no phase outputs
	function automatic logic [2:0] exp_phase(input int st, input logic [2:0] pp);
		return (st == 0) ? pp : 3'h0;
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one apb transfer; read data and error taken at the completing edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50) begin
			mismatches++;
			print_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// checks land one step after the edge so its updates have settled
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic drive(input int st, input logic [2:0] pp);
		@(posedge pclk);
		model.apply(st, pp);
	endtask

	task automatic clr();
		@(posedge pclk);
		model.clear_all();
		tick(4);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		lfsr = 32'hab38;
		mismatches = 0;
		check_count = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and an unmapped place
		apb(1'b0, `PROT_CTRL_OFS, 32'h0);
		check("ctrl reset", rd, `PROT_CTRL_RST);
		check("pready", pready, 1);
		apb(1'b0, `PROT_DELAY_BASE, 32'h0);
		check("delay reset", rd, `PROT_DELAY_RST);
		apb(1'b0, 12'h0fc, 32'h0);
		check("unmapped error", err, 1);
		// stage roles, breaker maps, delays, alarm interrupt unmasked
		apb(1'b1, `PROT_SUPERV_OFS, 32'h2);
		apb(1'b1, `PROT_SINGLE_OFS, 32'h3);
		apb(1'b1, `PROT_GROUND_OFS, 32'h4);
		apb(1'b1, `PROT_MAP_BASE, 32'h1);
		apb(1'b1, `PROT_MAP_BASE + 12'h004, 32'h6); // supervision stage listed, must never open it
		apb(1'b1, `PROT_DELAY_BASE, 32'h2);
		apb(1'b1, `PROT_DELAY_BASE + 12'h004, 32'h0);
		apb(1'b1, `PROT_DELAY_BASE + 12'h008, 32'h0);
		apb(1'b1, `PROT_DELAY_BASE + 12'h00c, 32'h4);
		apb(1'b1, `PROT_IRQ_MASK_OFS, 32'h1);
		// full walk of a protective stage with delay 2
		drive(0, 3'b001);
		tick(1);
		check("stage alarm", stage_alarm[0], 1);
		check("early trip", stage_trip[0], 0);
		tick(1);
		check("general alarm", collective.general_alarm, 1);
		check("phase alarm", collective.phase_alarm, 3'b001);
		tick(1);
		check("stage trip", stage_trip[0], 1);
		check("irq", irq, 1);
		tick(1);
		check("general trip", collective.general_trip, 1);
		check("phase trip", collective.phase_trip, 3'b001);
		check("command", stage_open_command[0], 1);
		tick(1);
		check("breaker", breaker_open, 2'b01);
		clr();
		apb(1'b1, `PROT_IRQ_STAT_OFS, 32'hf);
		tick(2);
		check("irq cleared", irq, 0);
		apb(1'b0, `PROT_STATUS_OFS, 32'h0);
		check("status idle", rd, 32'h200);
		// short fault restarts the timer from zero
		drive(3, 3'b100);
		tick(3);
		drive(3, 3'b000);
		tick(1);
		check("alarm dropped", stage_alarm[3], 0);
		drive(3, 3'b100);
		tick(4);
		check("restarted", stage_trip[3], 0);
		tick(1);
		check("late trip", stage_trip[3], 1);
		tick(1);
		check("no phase trip", collective.phase_trip, 3'b000);
		check("late command", stage_open_command[3], 1);
		tick(1);
		check("unmapped cmd", breaker_open, 2'b00);
		clr();
		// supervision stage stays local
		drive(1, 3'b010);
		tick(4);
		check("superv own alarm", stage_alarm[1], 1);
		check("superv alarm", collective.general_alarm, 0);
		check("superv phase", collective.phase_alarm, 3'b000);
		check("superv cmd", stage_open_command[1], 0);
		check("superv brk", breaker_open, 2'b00);
		clr();
		// ground stage
		drive(2, 3'b111);
		tick(4);
		check("ground alarm", collective.ground_alarm, 1);
		check("ground brk", breaker_open, 2'b10);
		clr();
		// blocking and inhibit table
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, `PROT_CTRL_OFS, {28'h0, ctl[i]});
			@(posedge pclk);
			model.set_block(pin[i]);
			tick(5);
			drive(0, 3'b001);
			tick(6);
			check("blk alarm", collective.general_alarm, pass[i][1]);
			check("blk trip", collective.general_trip, pass[i][1]);
			check("blk cmd", stage_open_command[0], pass[i][0]);
			check("blk brk", breaker_open, {1'b0, pass[i][0]});
			@(posedge pclk);
			model.set_block(3'h0);
			clr();
		end
		// random stages and phase patterns
		for (int i = 0; i < 12; i++) begin
			lfsr = next_rand(lfsr);
			p = lfsr[2:0];
			s = int'(lfsr[4:3]);
			drive(s, p);
			tick(2);
			check("rnd phase", collective.phase_alarm, exp_phase(s, p));
			check("rnd general", collective.general_alarm, (|p) && s != 1);
			check("rnd ground", collective.ground_alarm, (|p) && s == 2);
			clr();
		end
		print_verdict();
	end
endmodule
